// *** rtl/tx_payload_regs.sv ***
// transmit payload control register bank with AHB-Lite slave and channel stage
// assumes single word transfers; channel stream is synchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module tx_payload_regs
  import tpc_pkg::*;
#(
  parameter int          BUSY_CYCLES = 2,
  parameter logic [63:0] MW_ALAW     = 64'h0123456789ABCDEF,
  parameter logic [63:0] MW_ULAW     = 64'hFEDCBA9876543210
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // monitor overflow events and receive busy
  input  wire logic        fer_ovf_i,
  input  wire logic        crc_ovf_i,
  input  wire logic        lcv_ovf_i,
  input  wire logic        rx_busy_i,
  output logic             int_n_o,
  // channel stream in
  input  wire logic        ch_valid_i,
  input  wire logic [4:0]  ch_index_i,
  input  wire logic [7:0]  ch_data_i,
  input  wire logic [3:0]  transmit_signaling_input_i,
  input  wire logic [7:0]  loop_data_i,
  input  wire logic        mf_first_i,
  input  wire logic        sig_frame_i,
  input  wire logic        sf_format_i,
  input  wire logic        esf_slc_i,
  // channel stream out
  output logic             ch_valid_o,
  output logic [7:0]       ch_data_o,
  output logic [3:0]       ch_sig_o,
  output logic [7:0]       test_mask_o,
  // pattern generator control
  output logic             test_start_o,
  output logic             gen_in_tx_o,
  output logic             det_in_tx_o
);
  // bus address and data phase
  wire       ap_valid = hsel_i && hready_i && htrans_i[1];
  wire [7:0] ap_idx   = haddr_i[ADDR_LSB +: 8];
  logic       dp_wr;
  logic       dp_rd;
  logic [7:0] dp_idx;
  wire [7:0] wb       = hwdata_i[7:0];
  wire       wr_en0   = dp_wr && (dp_idx == IDX_IRQ_EN0);
  wire       wr_en1   = dp_wr && (dp_idx == IDX_IRQ_EN1);
  wire       wr_flg0  = dp_wr && (dp_idx == IDX_FLAGS0);
  wire       wr_flg1  = dp_wr && (dp_idx == IDX_FLAGS1);
  wire       wr_test  = dp_wr && (dp_idx == IDX_TEST);
  wire       wr_ctrl  = dp_wr && (dp_idx == IDX_TX_CTRL);
  wire       wr_data  = dp_wr && (dp_idx == IDX_TX_DATA);
  wire       wr_cfg   = dp_wr && (dp_idx == IDX_TX_CFG);
  wire       wr_en    = dp_wr && (dp_idx == IDX_TX_EN);

  // registers
  logic       fer_flag;
  logic       crc_flag;
  logic       lcv_flag;
  logic [1:0] irq_en0;
  logic       irq_en1;
  logic [3:0] test_cfg;
  logic [7:0] ind_ctrl;
  logic [7:0] ind_data;
  logic [7:0] cfg;
  logic       signaling_nibble_placement;
  logic       payload_control_enable;
  logic [2:0] mw_phase;
  logic [3:0] snap [0:NUM_CH-1];

  // indirect engine hookup
  logic       busy;
  logic       rdone;
  logic [7:0] rdata;
  logic [7:0] ch_sub;
  logic [7:0] ch_trunk;
  logic [7:0] ch_cfg;
  wire  [6:0] req_addr = wb[6:0];
  wire        addr_ok  = (req_addr >= SUB_LO && req_addr <= SUB_HI)
                      || (req_addr >= TRK_LO && req_addr <= TRK_HI)
                      || (req_addr >= CCF_LO && req_addr <= CCF_HI);
  wire        ctrl_take = wr_ctrl && !busy;
  wire        ind_start = ctrl_take && addr_ok;

  indirect_engine #(
    .BUSY_CYCLES (BUSY_CYCLES)
  ) u_engine (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .start_i (ind_start),
    .dir_i   (wb[DIR_BIT]),
    .addr_i  (req_addr),
    .wdata_i (ind_data),
    .busy_o  (busy),
    .rdone_o (rdone),
    .rdata_o (rdata),
    .ch_i    (ch_index_i),
    .sub_o   (ch_sub),
    .trunk_o (ch_trunk),
    .chcfg_o (ch_cfg)
  );

  // next values: set wins over a simultaneous write-one clear
  wire next_fer = fer_ovf_i || (fer_flag && !(wr_flg0 && wb[FER_BIT]));
  wire next_crc = crc_ovf_i || (crc_flag && !(wr_flg0 && wb[CRC_BIT]));
  wire next_lcv = lcv_ovf_i || (lcv_flag && !(wr_flg1 && wb[LCV_BIT]));
  wire irq_any  = (fer_flag && irq_en0[FER_BIT]) || (crc_flag && irq_en0[CRC_BIT])
               || (lcv_flag && irq_en1);
  wire next_start = wr_test && wb[START_BIT] && !test_cfg[START_BIT];
  wire [7:0] next_data = wr_data ? wb : rdone ? rdata : ind_data;

  // read mux
  wire [7:0] rd_byte =
      (dp_idx == IDX_IRQ_EN0) ? {6'h00, irq_en0}
    : (dp_idx == IDX_IRQ_EN1) ? {7'h00, irq_en1}
    : (dp_idx == IDX_FLAGS0)  ? {6'h00, fer_flag, crc_flag}
    : (dp_idx == IDX_FLAGS1)  ? {7'h00, lcv_flag}
    : (dp_idx == IDX_TEST)    ? {4'h0, test_cfg}
    : (dp_idx == IDX_TX_STAT) ? {7'h00, busy}
    : (dp_idx == IDX_TX_CTRL) ? ind_ctrl
    : (dp_idx == IDX_TX_DATA) ? ind_data
    : (dp_idx == IDX_TX_CFG)  ? cfg
    : (dp_idx == IDX_TX_EN)   ? {4'h0, signaling_nibble_placement, 2'b00, payload_control_enable}
    : (dp_idx == IDX_RX_STAT) ? {7'h00, rx_busy_i}
    : ZERO8;

  // channel datapath
  wire       snap_on  = payload_control_enable && cfg[SNAP_BIT] && sf_format_i;
  wire       ch_ok    = ch_index_i < 5'(NUM_CH);
  wire [3:0] sig_src  = (snap_on && !mf_first_i && ch_ok) ? snap[ch_index_i] : transmit_signaling_input_i;
  wire [7:0] mw_alaw  = MW_ALAW[{mw_phase, 3'b000} +: 8];
  wire [7:0] mw_ulaw  = MW_ULAW[{mw_phase, 3'b000} +: 8];
  logic [7:0] mux_data;
  logic [3:0] mux_sig;
  logic [7:0] mux_mask;

  payload_mux u_mux (
    .payload_control_enable_i      (payload_control_enable),
    .zcs_i       (cfg[ZCS_LSB +: 3]),
    .gsub_i      (cfg[GSUB_LSB +: 3]),
    .gstrk_i     (cfg[GSTRK_BIT]),
    .signaling_nibble_placement_i      (signaling_nibble_placement),
    .tmode_i     (test_cfg[TMODE_LSB +: 2]),
    .esf_slc_i   (esf_slc_i),
    .sig_frame_i (sig_frame_i),
    .data_i      (ch_data_i),
    .sig_i       (sig_src),
    .sub_i       (ch_sub),
    .trunk_i     (ch_trunk),
    .chcfg_i     (ch_cfg),
    .loop_i      (loop_data_i),
    .alaw_i      (mw_alaw),
    .ulaw_i      (mw_ulaw),
    .data_o      (mux_data),
    .sig_o       (mux_sig),
    .mask_o      (mux_mask)
  );

  // bus slave: writes complete at once, reads take one wait state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dp_wr       <= 1'b0;
      dp_rd       <= 1'b0;
      dp_idx      <= ZERO8;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (ce_i) begin
      dp_wr       <= ap_valid && hwrite_i && (hsize_i == 3'b010);
      dp_rd       <= ap_valid && !hwrite_i;
      hreadyout_o <= !(ap_valid && !hwrite_i);
      if (ap_valid) dp_idx <= ap_idx;
      if (dp_rd) hrdata_o <= {24'h00_0000, rd_byte};
    end
  end

  // status and control registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fer_flag     <= 1'b0;
      crc_flag     <= 1'b0;
      lcv_flag     <= 1'b0;
      irq_en0      <= 2'b00;
      irq_en1      <= 1'b0;
      int_n_o      <= 1'b1;
      test_cfg     <= 4'h0;
      test_start_o <= 1'b0;
      ind_ctrl     <= CTRL_RESET;
      ind_data     <= DATA_RESET;
      cfg          <= CFG_RESET;
      signaling_nibble_placement         <= 1'b0;
      payload_control_enable         <= 1'b0;
    end else if (ce_i) begin
      fer_flag     <= next_fer;
      crc_flag     <= next_crc;
      lcv_flag     <= next_lcv;
      int_n_o      <= !irq_any;
      test_start_o <= next_start;
      ind_data     <= next_data;
      if (wr_en0) irq_en0 <= wb[1:0];
      if (wr_en1) irq_en1 <= wb[0];
      if (wr_test) test_cfg <= wb[3:0];
      if (ctrl_take) ind_ctrl <= wb;
      if (wr_cfg) cfg <= wb;
      if (wr_en) begin
        signaling_nibble_placement <= wb[SIGNALING_NIBBLE_PLACEMENT_BIT];
        payload_control_enable <= wb[PAYLOAD_CONTROL_ENABLE_BIT];
      end
    end
  end

  // channel output stage and milliwatt phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch_valid_o  <= 1'b0;
      ch_data_o   <= ZERO8;
      ch_sig_o    <= 4'h0;
      test_mask_o <= ZERO8;
      gen_in_tx_o <= 1'b1;
      det_in_tx_o <= 1'b0;
      mw_phase    <= 3'b000;
    end else if (ce_i) begin
      ch_valid_o  <= ch_valid_i;
      gen_in_tx_o <= !test_cfg[TDIR_BIT];
      det_in_tx_o <= test_cfg[TDIR_BIT];
      if (ch_valid_i) begin
        ch_data_o   <= mux_data;
        ch_sig_o    <= mux_sig;
        test_mask_o <= mux_mask;
        if (ch_index_i == 5'(NUM_CH - 1)) mw_phase <= mw_phase + 3'b001;
      end
    end
  end

  // first-frame signaling snapshot, one nibble per channel
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_snap
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) snap[c] <= 4'h0;
        else if (ce_i && ch_valid_i && mf_first_i && ch_index_i == 5'(c)) snap[c] <= transmit_signaling_input_i;
      end
    end
  endgenerate

  // checks
  sequence s_read_cmd;
    ce_i && ind_start && wb[DIR_BIT];
  endsequence
  sequence s_busy_run;
    busy [*2];
  endsequence

  a_fer_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && fer_ovf_i |=> fer_flag) else $error("frame error flag not set");
  a_flag_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_flg1 && wb[LCV_BIT] && !lcv_ovf_i |=> !lcv_flag) else $error("lcv flag not cleared");
  a_irq_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && lcv_flag && !irq_en1 && !fer_flag && !crc_flag |=> int_n_o) else $error("irq not masked");
  a_start_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    test_start_o |-> test_cfg[START_BIT] && !$past(test_cfg[START_BIT])) else $error("start without edge");
  a_busy_ctrl_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && busy && wr_ctrl |=> $stable(ind_ctrl)) else $error("control changed while busy");
  a_read_busy_span: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_cmd |=> s_busy_run) else $error("busy too short after read");
  a_payload_control_enable_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ch_valid_i && !payload_control_enable |=> ch_data_o == $past(ch_data_i)) else $error("data altered while off");
  a_unframed_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ch_valid_i && test_cfg[TMODE_LSB +: 2] == TM_UNFRAMED |=> test_mask_o == MASK_ALL)
    else $error("unframed mask wrong");
  a_dds_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ch_valid_i && payload_control_enable && cfg == {2'b00, ZCS_DDS, SUB_NONE} && ch_sub[SUB_LSB +: 3] == SUB_NONE
    && ch_data_i == ZERO8 |=> ch_data_o == DDS_PATTERN) else $error("dds pattern missing");
endmodule
`default_nettype wire

// *** inc/tpc_pkg.sv ***
// constants, codes and register layout of the transmit payload register bank
// assumes one clock domain; every file imports the whole package
// Function
// - overflow flags set by counters, write-one clears
// - mode 00 tests all channels, ignores selection
// - mode 01 tests whole selected channels
// - mode 10 tests seven MSBs; 11 reserved
// - direction bit picks generating and detecting path
// - test starts only on rising start bit
// - busy flag high during indirect access
// - control: direction bit 7, address bits 6-0
// - indirect addresses only in three valid ranges
// - read command then data register holds byte
// - snapshot latches first-frame signaling for multiframe
// - global trunk conditioning overrides per-channel enable
// - bit 1 is MSB; code 000 off
// - code 001 bit 8, signaling frames bit 7
// - 010 jams bit 8; 011 sets bit 7
// - code 100 substitutes fixed pattern for zeros
// - substitution 000 per channel; 001 trunk code
// - 010 A-law, 011 mu-law milliwatt
// - substitution 100 uses receive loopback data
// - placement bit picks nibble or upper two bits
// - enable bit gates data and signaling paths; test mask is not gated
// - overflow flags raise interrupt only when enabled
package tpc_pkg;
  localparam int          NUM_CH   = 24;
  localparam int          ADDR_LSB = 2;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_EN0 = 8'hC3;
  localparam logic [7:0] IDX_IRQ_EN1 = 8'hC4;
  localparam logic [7:0] IDX_FLAGS0  = 8'hC5;
  localparam logic [7:0] IDX_FLAGS1  = 8'hC6;
  localparam logic [7:0] IDX_TEST    = 8'hC7;
  localparam logic [7:0] IDX_TX_STAT = 8'hC8;
  localparam logic [7:0] IDX_TX_CTRL = 8'hC9;
  localparam logic [7:0] IDX_TX_DATA = 8'hCA;
  localparam logic [7:0] IDX_TX_CFG  = 8'hCB;
  localparam logic [7:0] IDX_TX_EN   = 8'hCC;
  localparam logic [7:0] IDX_RX_STAT = 8'hCD;
  // field positions
  localparam int FER_BIT = 1, CRC_BIT = 0, LCV_BIT = 0;
  localparam int START_BIT = 0, TDIR_BIT = 1, TMODE_LSB = 2;
  localparam int DIR_BIT = 7, BUSY_BIT = 0;
  localparam int SNAP_BIT = 7, GSTRK_BIT = 6, ZCS_LSB = 3, GSUB_LSB = 0;
  localparam int SIGNALING_NIBBLE_PLACEMENT_BIT = 3, PAYLOAD_CONTROL_ENABLE_BIT = 0;
  localparam int SUB_LSB = 5, TSEL_BIT = 6, STRK_BIT = 4;
  // reset values
  localparam logic [7:0] CFG_RESET  = 8'h80;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // indirect address banks
  localparam logic [6:0] SUB_LO = 7'h01, SUB_HI = 7'h18;
  localparam logic [6:0] TRK_LO = 7'h21, TRK_HI = 7'h38;
  localparam logic [6:0] CCF_LO = 7'h41, CCF_HI = 7'h58;
  // data patterns and masks
  localparam logic [7:0] DDS_PATTERN = 8'h98;
  localparam logic [7:0] BIT8_MASK   = 8'h01;
  localparam logic [7:0] BIT7_MASK   = 8'h02;
  localparam logic [7:0] MASK_ALL    = 8'hFF;
  localparam logic [7:0] MASK_SEVEN  = 8'hFE;
  localparam logic [7:0] ZERO8       = 8'h00;
  typedef enum logic [2:0] {
    ZCS_NONE = 3'b000, ZCS_SIGAWARE = 3'b001, ZCS_JAM8 = 3'b010,
    ZCS_BIT7 = 3'b011, ZCS_DDS = 3'b100
  } zcs_e;
  typedef enum logic [2:0] {
    SUB_NONE = 3'b000, SUB_TRUNK = 3'b001, SUB_ALAW = 3'b010,
    SUB_ULAW = 3'b011, SUB_LOOP = 3'b100
  } channel_substitution_select_e;
  typedef enum logic [1:0] {
    TM_UNFRAMED = 2'b00, TM_BYTE = 2'b01, TM_SEVEN = 2'b10, TM_RSVD = 2'b11
  } tmode_e;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00, ENG_RUN = 2'b01
  } eng_e;
endpackage

// *** rtl/indirect_engine.sv ***
// per-channel indirect register store with busy handshake
// assumes requests arrive only while idle; the top enforces that
`timescale 1ns/1ns
`default_nettype none
module indirect_engine
  import tpc_pkg::*;
#(
  parameter int BUSY_CYCLES = 2
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // request
  input  wire logic       start_i,
  input  wire logic       dir_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] wdata_i,
  // answer
  output logic            busy_o,
  output logic            rdone_o,
  output logic [7:0]      rdata_o,
  // channel lookup
  input  wire logic [4:0] ch_i,
  output logic [7:0]      sub_o,
  output logic [7:0]      trunk_o,
  output logic [7:0]      chcfg_o
);
  localparam int DEPTH = 3 * NUM_CH;
  localparam logic [7:0] CNT_LOAD = 8'(BUSY_CYCLES - 1);
  logic [7:0] mem [0:DEPTH-1];
  eng_e       state;
  logic [7:0] cnt;
  logic       op_dir;
  logic [6:0] op_idx;
  wire        finish = (state == ENG_RUN) && (cnt == ZERO8);
  wire        in_sub = (addr_i >= SUB_LO) && (addr_i <= SUB_HI);
  wire        in_trk = (addr_i >= TRK_LO) && (addr_i <= TRK_HI);
  wire  [6:0] req_idx = in_sub ? 7'(addr_i - SUB_LO)
                      : in_trk ? 7'(addr_i - TRK_LO + 7'(NUM_CH))
                      : 7'(addr_i - CCF_LO + 7'(2 * NUM_CH));
  wire        ch_ok  = ch_i < 5'(NUM_CH);
  assign busy_o  = (state != ENG_IDLE);
  assign rdone_o = finish && op_dir;
  assign rdata_o = mem[op_idx];
  assign sub_o   = ch_ok ? mem[ch_i] : ZERO8;
  assign trunk_o = ch_ok ? mem[7'(ch_i) + 7'(NUM_CH)] : ZERO8;
  assign chcfg_o = ch_ok ? mem[7'(ch_i) + 7'(2 * NUM_CH)] : ZERO8;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state  <= ENG_IDLE;
      cnt    <= ZERO8;
      op_dir <= 1'b0;
      op_idx <= 7'h00;
    end else if (ce_i) begin
      case (state)
        ENG_IDLE: if (start_i) begin
          state  <= ENG_RUN;
          cnt    <= CNT_LOAD;
          op_dir <= dir_i;
          op_idx <= req_idx;
        end
        ENG_RUN: begin
          cnt <= cnt - 8'h01;
          if (finish) state <= ENG_IDLE;
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_mem
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) mem[g] <= ZERO8;
        else if (ce_i && finish && !op_dir && (op_idx == 7'(g))) mem[g] <= wdata_i;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** rtl/payload_mux.sv ***
// combinational per-channel substitution, zero suppression and signaling
// assumes the caller registers the outputs and picks the signaling source
`timescale 1ns/1ns
`default_nettype none
module payload_mux
  import tpc_pkg::*;
(
  // configuration
  input  wire logic       payload_control_enable_i,
  input  wire logic [2:0] zcs_i,
  input  wire logic [2:0] gsub_i,
  input  wire logic       gstrk_i,
  input  wire logic       signaling_nibble_placement_i,
  input  wire logic [1:0] tmode_i,
  // frame context
  input  wire logic       esf_slc_i,
  input  wire logic       sig_frame_i,
  // channel data and per-channel fields
  input  wire logic [7:0] data_i,
  input  wire logic [3:0] sig_i,
  input  wire logic [7:0] sub_i,
  input  wire logic [7:0] trunk_i,
  input  wire logic [7:0] chcfg_i,
  input  wire logic [7:0] loop_i,
  input  wire logic [7:0] alaw_i,
  input  wire logic [7:0] ulaw_i,
  // results
  output logic [7:0]      data_o,
  output logic [3:0]      sig_o,
  output logic [7:0]      mask_o
);
  wire [2:0] code   = (gsub_i == SUB_NONE) ? sub_i[SUB_LSB +: 3] : gsub_i;
  wire [7:0] subd   = (code == SUB_TRUNK) ? trunk_i
                    : (code == SUB_ALAW)  ? alaw_i
                    : (code == SUB_ULAW)  ? ulaw_i
                    : (code == SUB_LOOP)  ? loop_i
                    : data_i;
  wire       zero   = (subd == ZERO8);
  // bit 1 is the MSB, so bit 8 is [0] and bit 7 is [1]
  wire [7:0] zcsd   = (zcs_i == ZCS_SIGAWARE && zero) ? (sig_frame_i ? BIT7_MASK : BIT8_MASK)
                    : (zcs_i == ZCS_JAM8)             ? (subd | BIT8_MASK)
                    : (zcs_i == ZCS_BIT7 && zero)     ? BIT7_MASK
                    : (zcs_i == ZCS_DDS && zero)      ? DDS_PATTERN
                    : subd;
  wire [3:0] placed = (esf_slc_i && signaling_nibble_placement_i) ? {sig_i[3:2], sig_i[3:2]} : sig_i;
  wire       strk   = gstrk_i || chcfg_i[STRK_BIT];
  wire       tsel   = chcfg_i[TSEL_BIT];
  assign data_o = payload_control_enable_i ? zcsd : data_i;
  assign sig_o  = !payload_control_enable_i ? sig_i : strk ? chcfg_i[3:0] : placed;
  assign mask_o = (tmode_i == TM_UNFRAMED) ? MASK_ALL
                : (tmode_i == TM_BYTE)     ? (tsel ? MASK_ALL : ZERO8)
                : (tmode_i == TM_SEVEN)    ? (tsel ? MASK_SEVEN : ZERO8)
                : ZERO8;
endmodule
`default_nettype wire

// *** testbench/host_model.sv ***
// host model: AHB-Lite master issuing single word transfers
// assumes hready_i is the one slave's hreadyout
`timescale 1ns/1ns
`default_nettype none
module host_model
  import tpc_pkg::*;
(
  // clock and answer
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  // request
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  initial begin
    hsel_o   = 1'b1;
    haddr_o  = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h0;
  end
  // address phase held until accepted, then data phase held until ready
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(posedge clk_i);
    htrans_o <= 2'h2;
    haddr_o  <= {22'h0, idx, 2'h0};
    hwrite_o <= w;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= {24'h0, wd};
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd = hrdata_i[7:0];
  endtask
  // polls status so no new indirect op starts while busy
  task automatic wait_idle();
    logic [7:0] s;
    s = 8'hFF;
    while (s[BUSY_BIT] !== 1'b0) xfer(1'b0, IDX_TX_STAT, 8'h00, s);
  endtask
endmodule
`default_nettype wire

// *** testbench/test_transmit_payload_control_regs.sv ***
// self-checking bench for the transmit payload register bank
// assumes host_model drives the bus; busy stretched so overlaps can be hit
`timescale 1ns/1ns
`default_nettype none
module test_transmit_payload_control_regs;
  import tpc_pkg::*;
  localparam logic [63:0] MW_A = 64'h1122334455667788;
  localparam logic [63:0] MW_U = 64'h99AABBCCDDEEFF66;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic e; logic [7:0] x;} row_s;
  logic        clk_i, rst_i, hsel, hwrite, hready, hresp, int_n_o, rx_busy;
  logic        fer, crc, lcv, ch_valid, sig_frame, ch_valid_o, sf, mf, esf;
  logic [4:0]  ch_idx;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  ch_data, loop_data, ch_data_o, test_mask_o, r;
  logic [3:0]  ch_sig_o, transmit_signaling_input;
  logic        test_start_o, gen_in_tx_o, det_in_tx_o;
  int          n_mismatch, checks_done, starts;
  row_s        regs[5] = '{'{IDX_TEST, 8'h0A, 0, 8'h0A}, '{IDX_TX_CFG, 8'h5A, 0, 8'h5A},
    '{IDX_TX_EN, 8'h09, 0, 8'h09}, '{IDX_IRQ_EN1, 8'h01, 0, 8'h01}, '{8'h10, 8'hFF, 0, 8'h00}};
  // config byte, channel byte, signaling frame, expected byte
  row_s        chans[11] = '{'{8'h00, 8'h00, 0, 8'h00}, '{8'h08, 8'h00, 0, 8'h01},
    '{8'h08, 8'h00, 1, 8'h02}, '{8'h10, 8'h40, 0, 8'h41}, '{8'h18, 8'h00, 0, 8'h02},
    '{8'h18, 8'h40, 0, 8'h40}, '{8'h20, 8'h00, 0, 8'h98}, '{8'h02, 8'h33, 0, MW_A[7:0]},
    '{8'h03, 8'h33, 0, MW_U[7:0]}, '{8'h04, 8'h33, 0, 8'hC3}, '{8'h01, 8'h33, 0, 8'h5C}};
  tx_payload_regs #(.BUSY_CYCLES(8), .MW_ALAW(MW_A), .MW_ULAW(MW_U)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .fer_ovf_i(fer), .crc_ovf_i(crc), .lcv_ovf_i(lcv), .rx_busy_i(rx_busy),
    .int_n_o(int_n_o), .ch_valid_i(ch_valid), .ch_index_i(ch_idx), .ch_data_i(ch_data),
    .transmit_signaling_input_i(transmit_signaling_input), .loop_data_i(loop_data), .mf_first_i(mf), .sig_frame_i(sig_frame),
    .sf_format_i(sf), .esf_slc_i(esf), .ch_valid_o(ch_valid_o), .ch_data_o(ch_data_o),
    .ch_sig_o(ch_sig_o), .test_mask_o(test_mask_o), .test_start_o(test_start_o),
    .gen_in_tx_o(gen_in_tx_o), .det_in_tx_o(det_in_tx_o));
  host_model host (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));
  always @(posedge clk_i) if (test_start_o === 1'b1) starts++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
    host.xfer(1'b0, a, 8'h00, r);
    chk(r, x);
  endtask
  // one channel byte in, processed byte checked a cycle after it is taken
  task automatic chan(input logic [7:0] d, input logic sf, input logic [7:0] x);
    @(posedge clk_i);
    ch_valid  <= 1'b1;
    ch_data   <= d;
    sig_frame <= sf;
    @(posedge clk_i);
    ch_valid <= 1'b0;
    @(posedge clk_i);
    chk(ch_data_o, x);
    chk({hresp, ch_valid_o}, 2'b01);
  endtask
  task automatic pulse_all();
    @(posedge clk_i);
    {fer, crc, lcv} <= 3'b111;
    @(posedge clk_i);
    {fer, crc, lcv} <= 3'b000;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    #1000000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {rst_i, fer, crc, lcv, ch_valid, sig_frame, rx_busy, sf, mf, esf} = 10'h200;
    {ch_idx, transmit_signaling_input} = 9'h000;
    {ch_data, loop_data} = 16'h00C3;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].d);
      rdchk(regs[i].a, regs[i].x);
    end
    chk({gen_in_tx_o, det_in_tx_o}, 2'b01);
    $display("register rows done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(IDX_TX_CFG, CFG_RESET);
    rdchk(IDX_TX_CTRL, CTRL_RESET);
    rdchk(IDX_TX_DATA, DATA_RESET);
    rdchk(IDX_TX_EN, 8'h00);
    chk({gen_in_tx_o, det_in_tx_o}, 2'b10);
    $display("reset done");
    wr(IDX_TX_DATA, 8'h5C);
    wr(IDX_TX_CTRL, 8'h21);
    host.wait_idle();
    wr(IDX_TX_CTRL, 8'hA1);
    wr(IDX_TX_CTRL, 8'h22);
    host.wait_idle();
    rdchk(IDX_TX_CTRL, 8'hA1);
    rdchk(IDX_TX_DATA, 8'h5C);
    wr(IDX_TX_CTRL, 8'h19);
    rdchk(IDX_TX_STAT, 8'h00);
    rx_busy <= 1'b1;
    rdchk(IDX_RX_STAT, 8'h01);
    $display("indirect done");
    wr(IDX_TX_EN, 8'h01);
    foreach (chans[i]) begin
      wr(IDX_TX_CFG, chans[i].a);
      chan(chans[i].d, chans[i].e, chans[i].x);
    end
    chk(test_mask_o, 8'hFF);
    wr(IDX_TEST, 8'h04);
    chan(8'h33, 1'b0, 8'h5C);
    chk(test_mask_o, 8'h00);
    ch_idx <= 5'd1;
    chan(8'h33, 1'b0, 8'h00);
    ch_idx <= 5'd0;
    wr(IDX_TX_DATA, 8'h4A);
    wr(IDX_TX_CTRL, 8'h41);
    host.wait_idle();
    chan(8'h33, 1'b0, 8'h5C);
    chk(test_mask_o, 8'hFF);
    wr(IDX_TEST, 8'h08);
    chan(8'h33, 1'b0, 8'h5C);
    chk(test_mask_o, 8'hFE);
    {esf, transmit_signaling_input} <= 5'h1C;
    wr(IDX_TX_EN, 8'h09);
    chan(8'h33, 1'b0, 8'h5C);
    chk(ch_sig_o, 4'hF);
    wr(IDX_TX_CFG, 8'h41);
    chan(8'h33, 1'b0, 8'h5C);
    chk(ch_sig_o, 4'hA);
    wr(IDX_TX_EN, 8'h01);
    wr(IDX_TX_CFG, 8'h80);
    {sf, mf, transmit_signaling_input} <= 6'h35;
    chan(8'h33, 1'b0, 8'h33);
    chk(ch_sig_o, 4'h5);
    {mf, transmit_signaling_input} <= 5'h03;
    chan(8'h33, 1'b0, 8'h33);
    chk(ch_sig_o, 4'h5);
    wr(IDX_TX_EN, 8'h00);
    wr(IDX_TX_CFG, 8'h10);
    chan(8'h40, 1'b0, 8'h40);
    chk(ch_sig_o, 4'h3);
    $display("channel rows done");
    pulse_all();
    rdchk(IDX_FLAGS0, 8'h03);
    rdchk(IDX_FLAGS1, 8'h01);
    chk(int_n_o, 1'b1);
    wr(IDX_IRQ_EN0, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(int_n_o, 1'b0);
    wr(IDX_FLAGS0, 8'h01);
    rdchk(IDX_FLAGS0, 8'h02);
    wr(IDX_FLAGS0, 8'h02);
    wr(IDX_FLAGS1, 8'h01);
    rdchk(IDX_FLAGS0, 8'h00);
    rdchk(IDX_FLAGS1, 8'h00);
    chk(int_n_o, 1'b1);
    $display("flags done");
    starts = 0;
    wr(IDX_TEST, 8'h01);
    wr(IDX_TEST, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(starts, 1);
    wr(IDX_TEST, 8'h00);
    wr(IDX_TEST, 8'h03);
    repeat (2) @(posedge clk_i);
    chk(starts, 2);
    chk({gen_in_tx_o, det_in_tx_o}, 2'b01);
    $display("pattern start done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
